/* logic/cab_exec.sv */
// Decode and execute unit for logic, multiply, call, return, compare and skip operations
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////
// Operation
// - OR with constant, flags Z N V, one cycle
// - Test ANDs register with itself, one cycle
// - Multiplies write r1:r0, flags Z C, two cycles
// - Scaled multiplies shift product left one
// - Relative call: PC plus offset plus one, three cycles
// - Indirect call loads PC from Z, three cycles
// - Direct call loads absolute target, four cycles
// - Return pops PC, flags kept, four cycles
// - Interrupt return pops PC, sets enable
// - Compare skip if equal, one to three cycles
// - Compare immediate updates Z N V C H
// - Skip on register bit clear or set
// - Skip on I/O bit clear or set
module cab_exec
    import cab_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                clk_en,
    input  wire logic                op_valid,
    output logic                     op_ready,
    input  wire cab_op_t             op_code,
    input  wire logic [REG_AW-1:0]   op_dst,
    input  wire logic [REG_AW-1:0]   op_src,
    input  wire logic [7:0]          op_imm,
    input  wire logic [2:0]          op_bit,
    input  wire logic [OFFSET_W-1:0] op_offset,
    input  wire logic [PC_W-1:0]     op_target,
    input  wire logic                next_two_word,
    input  wire logic                io_bit_value,
    input  wire logic [REG_AW-1:0]   peek_addr,
    output logic      [7:0]          peek_data_r,
    output logic      [PC_W-1:0]     pc_r,
    output logic                     flag_z_r,
    output logic                     flag_n_r,
    output logic                     flag_v_r,
    output logic                     flag_c_r,
    output logic                     flag_h_r,
    output logic                     gie_r
);

    //////////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic is_mul(input cab_op_t op);
        is_mul = op inside {CAB_OP_PRODUCT_UNSIGNED, CAB_OP_PRODUCT_SIGNED,
                            CAB_OP_PRODUCT_SIGNED_BY_UNSIGNED, CAB_OP_SCALED_PRODUCT_UNSIGNED,
                            CAB_OP_SCALED_PRODUCT_SIGNED, CAB_OP_SCALED_PRODUCT_MIXED};
    endfunction

    function automatic logic is_skip(input cab_op_t op);
        is_skip = op inside {CAB_OP_COMPARE_SKIP_EQUAL, CAB_OP_SKIP_REG_BIT_CLEAR,
                             CAB_OP_SKIP_REG_BIT_SET, CAB_OP_SKIP_IO_BIT_CLEAR,
                             CAB_OP_SKIP_IO_BIT_SET};
    endfunction

    function automatic logic is_call(input cab_op_t op);
        is_call = op inside {CAB_OP_RELATIVE_SUBROUTINE_JUMP, CAB_OP_INDIRECT_SUBROUTINE_JUMP,
                             CAB_OP_DIRECT_SUBROUTINE_JUMP};
    endfunction

    function automatic logic is_exit(input cab_op_t op);
        is_exit = (op == CAB_OP_SUBROUTINE_EXIT) || (op == CAB_OP_INTERRUPT_EXIT);
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]          regs [REG_NUM];
    logic [1:0]          cnt_r;
    cab_op_t             op_r;
    logic [STACK_AW-1:0] sp_r;
    logic                acc;
    logic                final_cyc;
    logic                mul_wb;
    logic [7:0]          rd_val;
    logic [7:0]          rr_val;
    logic [7:0]          or_res;
    logic [7:0]          sub_b;
    logic [7:0]          sub_res;
    logic                skip_taken;
    logic [1:0]          extra;
    logic [PC_W-1:0]     rel_tgt;
    logic [PC_W-1:0]     ptr_z;
    logic [PC_W-1:0]     pc_nxt;
    logic [PC_W-1:0]     push_val;
    logic [15:0]         mul_prod;
    logic                mul_carry;
    logic [PC_W-1:0]     pop_data;

    assign op_ready  = (cnt_r == 2'h0);
    assign acc       = clk_en && op_valid && op_ready;
    assign final_cyc = (cnt_r == 2'h1);
    assign mul_wb    = final_cyc && is_mul(op_r);
    assign rd_val    = regs[op_dst];
    assign rr_val    = regs[op_src];
    assign or_res    = rd_val | op_imm;
    assign ptr_z     = {regs[PTR_HI_IDX], regs[PTR_LO_IDX]};
    assign rel_tgt   = pc_r + {{(PC_W-OFFSET_W){op_offset[OFFSET_W-1]}}, op_offset}
                       + 16'h0001;

    // Subtrahend for the compare operations; carry-in only for compare with carry
    assign sub_b   = (op_code == CAB_OP_COMPARE_IMMEDIATE) ? op_imm : rr_val;
    assign sub_res = rd_val - sub_b
                     - {7'h00, (op_code == CAB_OP_COMPARE_WITH_CARRY) & flag_c_r};

    //////////////////////////////////////////////////////////////////////////////////////
    // Skip decision and cycle count

    always_comb
    begin
        case (op_code)
            CAB_OP_COMPARE_SKIP_EQUAL: skip_taken = (rd_val == rr_val);
            CAB_OP_SKIP_REG_BIT_CLEAR: skip_taken = !rr_val[op_bit];
            CAB_OP_SKIP_REG_BIT_SET:   skip_taken = rr_val[op_bit];
            CAB_OP_SKIP_IO_BIT_CLEAR:  skip_taken = !io_bit_value;
            CAB_OP_SKIP_IO_BIT_SET:    skip_taken = io_bit_value;
            default:                   skip_taken = 1'b0;
        endcase
    end

    always_comb
    begin
        if (is_mul(op_code))
            extra = EXTRA_MUL;
        else if (op_code == CAB_OP_RELATIVE_JUMP)
            extra = EXTRA_JUMP;
        else if (op_code == CAB_OP_RELATIVE_SUBROUTINE_JUMP
                 || op_code == CAB_OP_INDIRECT_SUBROUTINE_JUMP)
            extra = EXTRA_CALL;
        else if (op_code == CAB_OP_DIRECT_SUBROUTINE_JUMP || is_exit(op_code))
            extra = EXTRA_FAR;
        else if (is_skip(op_code) && skip_taken)
            extra = next_two_word ? EXTRA_SKIP2 : EXTRA_SKIP1;
        else
            extra = EXTRA_ONE;
    end

    always_comb
    begin
        case (op_code)
            CAB_OP_RELATIVE_JUMP,
            CAB_OP_RELATIVE_SUBROUTINE_JUMP: pc_nxt = rel_tgt;
            CAB_OP_INDIRECT_SUBROUTINE_JUMP: pc_nxt = ptr_z;
            CAB_OP_DIRECT_SUBROUTINE_JUMP:   pc_nxt = op_target;
            CAB_OP_SUBROUTINE_EXIT,
            CAB_OP_INTERRUPT_EXIT:           pc_nxt = pc_r;
            default:                         pc_nxt = pc_r + 16'h0001
                                                      + (skip_taken ? {14'h0000, extra} : 16'h0000);
        endcase
    end

    // A direct call is two words long, so it returns two words on
    assign push_val = (op_code == CAB_OP_DIRECT_SUBROUTINE_JUMP) ? pc_r + 16'h0002
                                                                 : pc_r + 16'h0001;

    //////////////////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 2'h0;
            op_r  <= CAB_OP_NONE;
        end
        else if (acc)
        begin
            cnt_r <= extra;
            op_r  <= op_code;
        end
        else if (clk_en && !op_ready)
            cnt_r <= cnt_r - 2'h1;
    end

    // Returns take the popped address in their last cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            pc_r <= PC_RESET;
        else if (acc)
            pc_r <= pc_nxt;
        else if (clk_en && final_cyc && is_exit(op_r))
            pc_r <= pop_data;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            gie_r <= 1'b0;
        else if (clk_en && final_cyc && op_r == CAB_OP_INTERRUPT_EXIT)
            gie_r <= 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Return stack

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            sp_r <= SP_RESET;
        else if (acc && is_call(op_code))
            sp_r <= sp_r + 4'h1;
        // Pop in the last cycle so the read address still points at the top entry
        else if (clk_en && final_cyc && is_exit(op_r))
            sp_r <= sp_r - 4'h1;
    end

    cab_stack_mem u_stack (
        .clock     (clock),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .wr_en     (acc && is_call(op_code)),
        .wr_addr   (sp_r),
        .wr_data   (push_val),
        .rd_addr   (sp_r - 4'h1),
        .rd_data_r (pop_data)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // Multiplier

    cab_mul u_mul (
        .clock     (clock),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .start     (acc && is_mul(op_code)),
        .mul_a     (rd_val),
        .mul_b     (rr_val),
        .a_signed  (op_code inside {CAB_OP_PRODUCT_SIGNED, CAB_OP_PRODUCT_SIGNED_BY_UNSIGNED,
                                    CAB_OP_SCALED_PRODUCT_SIGNED, CAB_OP_SCALED_PRODUCT_MIXED}),
        .b_signed  (op_code inside {CAB_OP_PRODUCT_SIGNED, CAB_OP_SCALED_PRODUCT_SIGNED}),
        .scaled    (op_code inside {CAB_OP_SCALED_PRODUCT_UNSIGNED,
                                    CAB_OP_SCALED_PRODUCT_SIGNED, CAB_OP_SCALED_PRODUCT_MIXED}),
        .product_r (mul_prod),
        .carry_r   (mul_carry)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // Register file

    generate
        for (genvar i = 0; i < REG_NUM; i++)
        begin : g_reg
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    regs[i] <= REG_RESET;
                else if (clk_en && mul_wb && i == PROD_LO_IDX)
                    regs[i] <= mul_prod[7:0];
                else if (clk_en && mul_wb && i == PROD_HI_IDX)
                    regs[i] <= mul_prod[15:8];
                else if (acc && op_code == CAB_OP_OR_CONST && op_dst == i)
                    regs[i] <= or_res;
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            peek_data_r <= REG_RESET;
        else if (clk_en)
            peek_data_r <= regs[peek_addr];
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Status flags

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_z_r <= 1'b0;
            flag_n_r <= 1'b0;
            flag_v_r <= 1'b0;
            flag_c_r <= 1'b0;
            flag_h_r <= 1'b0;
        end
        else if (clk_en && mul_wb)
        begin
            flag_z_r <= (mul_prod == 16'h0000);
            flag_c_r <= mul_carry;
        end
        else if (acc && op_code == CAB_OP_OR_CONST)
        begin
            flag_z_r <= (or_res == 8'h00);
            flag_n_r <= or_res[7];
            flag_v_r <= 1'b0;
        end
        else if (acc && op_code == CAB_OP_ZERO_MINUS_TEST)
        begin
            flag_z_r <= ((rd_val & rd_val) == 8'h00);
            flag_n_r <= rd_val[7];
            flag_v_r <= 1'b0;
        end
        else if (acc && (op_code == CAB_OP_COMPARE_IMMEDIATE
                         || op_code == CAB_OP_COMPARE_WITH_CARRY))
        begin
            // Compare with carry keeps Z cleared once any byte differed
            flag_z_r <= (sub_res == 8'h00)
                        && (op_code == CAB_OP_COMPARE_IMMEDIATE || flag_z_r);
            flag_n_r <= sub_res[7];
            flag_v_r <= (rd_val[7] & !sub_b[7] & !sub_res[7])
                        | (!rd_val[7] & sub_b[7] & sub_res[7]);
            flag_c_r <= (!rd_val[7] & sub_b[7]) | (sub_b[7] & sub_res[7])
                        | (sub_res[7] & !rd_val[7]);
            flag_h_r <= (!rd_val[3] & sub_b[3]) | (sub_b[3] & sub_res[3])
                        | (sub_res[3] & !rd_val[3]);
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n || !clk_en);

    a_or_flags: assert property (acc && op_code == CAB_OP_OR_CONST
        |=> op_ready && flag_z_r == ($past(or_res) == 8'h00) && !flag_v_r)
        else $error("or flags wrong");
    a_test_flags: assert property (acc && op_code == CAB_OP_ZERO_MINUS_TEST
        |=> op_ready && flag_n_r == $past(rd_val[7]))
        else $error("test flags wrong");
    a_mul_timing: assert property (acc && is_mul(op_code)
        |=> !op_ready ##1 op_ready && {regs[1], regs[0]} == $past(mul_prod))
        else $error("multiply result or timing wrong");
    a_scaled_lsb: assert property (acc && op_code == CAB_OP_SCALED_PRODUCT_UNSIGNED
        |=> ##1 !regs[0][0])
        else $error("scaled product not shifted");
    a_rel_call: assert property (acc && op_code == CAB_OP_RELATIVE_SUBROUTINE_JUMP
        |=> pc_r == $past(rel_tgt) && !op_ready ##1 !op_ready ##1 op_ready)
        else $error("relative call wrong");
    a_ind_call: assert property (acc && op_code == CAB_OP_INDIRECT_SUBROUTINE_JUMP
        |=> pc_r == $past(ptr_z) && sp_r == $past(sp_r) + 4'h1)
        else $error("indirect call wrong");
    a_dir_call: assert property (acc && op_code == CAB_OP_DIRECT_SUBROUTINE_JUMP
        |=> pc_r == $past(op_target) ##0 !op_ready[*3] ##1 op_ready)
        else $error("direct call wrong");
    a_exit_len: assert property (acc && is_exit(op_code)
        |=> !op_ready[*3] ##1 op_ready && $stable(flag_z_r))
        else $error("return length wrong");
    a_interrupt_exit_gie: assert property (acc && op_code == CAB_OP_INTERRUPT_EXIT
        |=> ##3 gie_r)
        else $error("interrupt enable not set");
    a_skip_cost: assert property (acc && is_skip(op_code) && !skip_taken
        |=> op_ready && pc_r == $past(pc_r) + 16'h0001)
        else $error("untaken skip wrong");
    a_skip_two: assert property (acc && is_skip(op_code) && skip_taken && next_two_word
        |=> pc_r == $past(pc_r) + 16'h0003 ##2 op_ready)
        else $error("two-word skip wrong");

    c_mul:    cover property (acc && is_mul(op_code));
    c_return: cover property (acc && op_code == CAB_OP_INTERRUPT_EXIT);
    c_skip:   cover property (acc && is_skip(op_code) && skip_taken && next_two_word);

endmodule
`default_nettype wire

/* logic/cab_pkg.sv */
// Shared constants and operation codes for the arithmetic and branch execute unit
package cab_pkg;

    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PC_W        = 16;
    localparam int unsigned REG_NUM     = 32;
    localparam int unsigned REG_AW      = 5;
    localparam int unsigned OFFSET_W    = 12;
    localparam int unsigned STACK_AW    = 4;

    // Register indices with a fixed role
    localparam logic [4:0] PROD_LO_IDX  = 5'h00;
    localparam logic [4:0] PROD_HI_IDX  = 5'h01;
    localparam logic [4:0] PTR_LO_IDX   = 5'h1E;
    localparam logic [4:0] PTR_HI_IDX   = 5'h1F;

    // Reset values
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [3:0]  SP_RESET    = 4'h0;

    // Extra cycles beyond the first, per operation class
    localparam logic [1:0] EXTRA_ONE    = 2'h0;
    localparam logic [1:0] EXTRA_MUL    = 2'h1;
    localparam logic [1:0] EXTRA_JUMP   = 2'h1;
    localparam logic [1:0] EXTRA_CALL   = 2'h2;
    localparam logic [1:0] EXTRA_FAR    = 2'h3;
    localparam logic [1:0] EXTRA_SKIP1  = 2'h1;
    localparam logic [1:0] EXTRA_SKIP2  = 2'h2;

    typedef enum logic [4:0] {
        CAB_OP_NONE,
        CAB_OP_OR_CONST,
        CAB_OP_ZERO_MINUS_TEST,
        CAB_OP_PRODUCT_UNSIGNED,
        CAB_OP_PRODUCT_SIGNED,
        CAB_OP_PRODUCT_SIGNED_BY_UNSIGNED,
        CAB_OP_SCALED_PRODUCT_UNSIGNED,
        CAB_OP_SCALED_PRODUCT_SIGNED,
        CAB_OP_SCALED_PRODUCT_MIXED,
        CAB_OP_RELATIVE_JUMP,
        CAB_OP_RELATIVE_SUBROUTINE_JUMP,
        CAB_OP_INDIRECT_SUBROUTINE_JUMP,
        CAB_OP_DIRECT_SUBROUTINE_JUMP,
        CAB_OP_SUBROUTINE_EXIT,
        CAB_OP_INTERRUPT_EXIT,
        CAB_OP_COMPARE_SKIP_EQUAL,
        CAB_OP_COMPARE_WITH_CARRY,
        CAB_OP_COMPARE_IMMEDIATE,
        CAB_OP_SKIP_REG_BIT_CLEAR,
        CAB_OP_SKIP_REG_BIT_SET,
        CAB_OP_SKIP_IO_BIT_CLEAR,
        CAB_OP_SKIP_IO_BIT_SET
    } cab_op_t;

endpackage

/* logic/cab_mul.sv */
// Registered 8x8 multiplier with signed, mixed and scaled forms
`timescale 1ns/1ps
`default_nettype none
module cab_mul
    import cab_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic        start,
    input  wire logic [7:0]  mul_a,
    input  wire logic [7:0]  mul_b,
    input  wire logic        a_signed,
    input  wire logic        b_signed,
    input  wire logic        scaled,
    output logic      [15:0] product_r,
    output logic             carry_r
);

    logic signed [8:0]  a_ext;
    logic signed [8:0]  b_ext;
    logic signed [17:0] raw;

    assign a_ext = {a_signed & mul_a[7], mul_a};
    assign b_ext = {b_signed & mul_b[7], mul_b};
    assign raw   = a_ext * b_ext;

    // Carry reports bit 15 of the unscaled product
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            product_r <= 16'h0000;
            carry_r   <= 1'b0;
        end
        else if (clk_en && start)
        begin
            product_r <= scaled ? {raw[14:0], 1'b0} : raw[15:0];
            carry_r   <= raw[15];
        end
    end

endmodule
`default_nettype wire

/* logic/cab_stack_mem.sv */
// Return address stack storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module cab_stack_mem
    import cab_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                clk_en,
    input  wire logic                wr_en,
    input  wire logic [STACK_AW-1:0] wr_addr,
    input  wire logic [PC_W-1:0]     wr_data,
    input  wire logic [STACK_AW-1:0] rd_addr,
    output logic      [PC_W-1:0]     rd_data_r
);

    logic [PC_W-1:0] mem [2**STACK_AW];

    always_ff @(posedge clock)
    begin
        if (clk_en && wr_en)
            mem[wr_addr] <= wr_data;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rd_data_r <= PC_RESET;
        else if (clk_en)
            rd_data_r <= mem[rd_addr];
    end

endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking testbench for the arithmetic and branch execute unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cab_pkg::*;
    typedef struct {string what; logic [2:0] sel; logic [15:0] exp;} cab_note_t;
    logic        clock, arst_n, clk_en, op_valid, op_ready, next_two_word, io_bit_value;
    logic        flag_z_r, flag_n_r, flag_v_r, flag_c_r, flag_h_r, gie_r, obs_req, egie;
    cab_op_t     op_code;
    logic [4:0]  op_dst, op_src, peek_addr, ef;
    logic [7:0]  op_imm, peek_data_r, rnd;
    logic [2:0]  op_bit;
    logic [11:0] op_offset;
    logic [15:0] op_target, pc_r, epc;
    logic [7:0]  rm [32];
    logic [15:0] stk [$];
    cab_note_t   q [$];
    cab_note_t   nt;
    int          ec, obs_cyc, n_errors, tests_run, i;

    cab_exec u_dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .op_dst(op_dst), .op_src(op_src),
        .op_imm(op_imm), .op_bit(op_bit), .op_offset(op_offset), .op_target(op_target),
        .next_two_word(next_two_word), .io_bit_value(io_bit_value), .peek_addr(peek_addr),
        .peek_data_r(peek_data_r), .pc_r(pc_r), .flag_z_r(flag_z_r), .flag_n_r(flag_n_r),
        .flag_v_r(flag_v_r), .flag_c_r(flag_c_r), .flag_h_r(flag_h_r), .gie_r(gie_r));

    initial
    begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Takes every pending note when the driver flags a settled result
    always @(posedge clock)
    begin
        if (obs_req === 1'h1)
            while (q.size() > 0)
            begin
                nt = q.pop_front();
                case (nt.sel)
                    3'h0: check(nt.what, pc_r, nt.exp);
                    3'h1: check(nt.what, {8'h00, peek_data_r}, nt.exp);
                    3'h2: check(nt.what, {11'h000, flag_z_r, flag_n_r, flag_v_r, flag_c_r,
                                           flag_h_r}, nt.exp);
                    3'h3: check(nt.what, {15'h0000, gie_r}, nt.exp);
                    default: check(nt.what, obs_cyc[15:0], nt.exp);
                endcase
            end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt();
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        return rnd;
    endfunction

    task automatic strobe();
        @(posedge clock);
        #1 obs_req = 1'h1;
        @(posedge clock);
        #1 obs_req = 1'h0;
    endtask

    task automatic look(logic [4:0] pk);
        q.push_back('{"peek", 3'h1, {8'h00, rm[pk]}});
        @(posedge clock);
        peek_addr <= pk;
        strobe();
    endtask

    task automatic op(cab_op_t c, logic [4:0] d, logic [4:0] s, logic [7:0] k, logic [15:0] t,
                      logic [2:0] b, logic two, logic io, logic [4:0] pk);
        q.push_back('{"pc", 3'h0, epc});
        q.push_back('{"peek", 3'h1, {8'h00, rm[pk]}});
        q.push_back('{"flags", 3'h2, {11'h000, ef}});
        q.push_back('{"gie", 3'h3, {15'h0000, egie}});
        q.push_back('{"cycles", 3'h4, ec[15:0]});
        @(posedge clock);
        op_code <= c; op_dst <= d; op_src <= s; op_imm <= k; op_bit <= b;
        op_offset <= t[11:0]; op_target <= t; next_two_word <= two; io_bit_value <= io;
        peek_addr <= pk; op_valid <= 1'h1;
        @(posedge clock);
        op_valid <= 1'h0;
        #1;
        obs_cyc = 1;
        while (op_ready !== 1'h1 && obs_cyc < 9)
        begin
            @(posedge clock);
            #1;
            obs_cyc++;
        end
        if (obs_cyc >= 9)
        begin
            n_errors++;
            finish_test();
        end
        strobe();
    endtask

    task automatic lop(cab_op_t c, logic [4:0] d, logic [7:0] k);
        if (c == CAB_OP_OR_CONST)
            rm[d] = rm[d] | k;
        ef = {rm[d] == 8'h00, rm[d][7], 1'h0, ef[1:0]};
        epc = epc + 16'h0001;
        ec = 1;
        op(c, d, d, k, 16'h0000, 3'h0, 1'h0, 1'h0, d);
    endtask

    task automatic compare_immediate(logic [4:0] d, logic [7:0] k);
        logic [7:0] a, r;
        a = rm[d];
        r = a - k;
        ef = {r == 8'h00, r[7], (a[7] & ~k[7] & ~r[7]) | (~a[7] & k[7] & r[7]), k > a,
              k[3:0] > a[3:0]};
        epc = epc + 16'h0001;
        ec = 1;
        op(CAB_OP_COMPARE_IMMEDIATE, d, 5'h00, k, 16'h0000, 3'h0, 1'h0, 1'h0, d);
    endtask

    task automatic mul(cab_op_t c, logic sa, logic sb, logic sc);
        int ia, ib;
        logic [15:0] p, w;
        ia = sa ? int'($signed(rm[16])) : int'(rm[16]);
        ib = sb ? int'($signed(rm[17])) : int'(rm[17]);
        p = 16'(ia * ib);
        w = sc ? {p[14:0], 1'h0} : p;
        rm[0] = w[7:0];
        rm[1] = w[15:8];
        ef = {w == 16'h0000, ef[3:2], p[15], ef[0]};
        epc = epc + 16'h0001;
        ec = 2;
        op(c, 5'h10, 5'h11, 8'h00, 16'h0000, 3'h0, 1'h0, 1'h0, 5'h01);
        look(5'h00);
    endtask

    task automatic call(cab_op_t c, logic [15:0] t);
        logic dir;
        dir = c == CAB_OP_DIRECT_SUBROUTINE_JUMP;
        if (c == CAB_OP_SUBROUTINE_EXIT || c == CAB_OP_INTERRUPT_EXIT)
        begin
            epc = stk.pop_back();
            ec = 4;
            egie = egie | (c == CAB_OP_INTERRUPT_EXIT);
        end
        else
        begin
            stk.push_back(epc + (dir ? 16'h0002 : 16'h0001));
            ec = dir ? 4 : 3;
            epc = dir ? t : c == CAB_OP_INDIRECT_SUBROUTINE_JUMP ? {rm[31], rm[30]} :
                  epc + {{4{t[11]}}, t[11:0]} + 16'h0001;
        end
        op(c, 5'h00, 5'h00, 8'h00, t, 3'h0, 1'h0, 1'h0, 5'h00);
    endtask

    task automatic skp(int j);
        cab_op_t c;
        logic [2:0] b;
        logic [4:0] s;
        logic tk;
        b = 3'(nxt());
        s = (j < 4 && !j[1]) ? 5'h11 : 5'h10;
        c = j < 4 ? CAB_OP_COMPARE_SKIP_EQUAL : j < 8 ? CAB_OP_SKIP_REG_BIT_CLEAR :
            j < 12 ? CAB_OP_SKIP_REG_BIT_SET : j < 16 ? CAB_OP_SKIP_IO_BIT_CLEAR :
            CAB_OP_SKIP_IO_BIT_SET;
        tk = j < 4 ? rm[16] == rm[s] : j < 8 ? !rm[16][b] : j < 12 ? rm[16][b] :
             j < 16 ? !j[1] : j[1];
        ec = tk ? (j[0] ? 3 : 2) : 1;
        epc = epc + 16'(ec);
        op(c, 5'h10, s, 8'h00, 16'h0000, b, j[0], j[1], 5'h10);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        arst_n = 1'h0; clk_en = 1'h1; op_valid = 1'h0; op_code = CAB_OP_NONE; op_dst = 5'h00;
        op_src = 5'h00; op_imm = 8'h00; op_bit = 3'h0; op_offset = 12'h000;
        op_target = 16'h0000; next_two_word = 1'h0; io_bit_value = 1'h0; peek_addr = 5'h00;
        obs_req = 1'h0; n_errors = 0; tests_run = 0; rnd = 8'h08; epc = 16'h0000;
        ef = 5'h00; egie = 1'h0;
        foreach (rm[k])
            rm[k] = 8'h00;
        repeat (5) @(posedge clock);
        arst_n <= 1'h1;
        lop(CAB_OP_OR_CONST, 5'h14, 8'h00);
        for (i = 0; i < 4; i++)
            lop(CAB_OP_OR_CONST, 5'(16 + i % 2), nxt());
        lop(CAB_OP_OR_CONST, 5'h10, 8'h80);
        lop(CAB_OP_ZERO_MINUS_TEST, 5'h10, 8'h00);
        lop(CAB_OP_ZERO_MINUS_TEST, 5'h14, 8'h00);
        // Clock enable low: the offered operation must leave every state untouched
        @(posedge clock);
        clk_en <= 1'h0;
        ec = 1;
        op(CAB_OP_OR_CONST, 5'h14, 5'h14, 8'hFF, 16'h0000, 3'h0, 1'h0, 1'h0, 5'h14);
        @(posedge clock);
        clk_en <= 1'h1;
        mul(CAB_OP_PRODUCT_UNSIGNED, 1'h0, 1'h0, 1'h0);
        mul(CAB_OP_PRODUCT_SIGNED, 1'h1, 1'h1, 1'h0);
        mul(CAB_OP_PRODUCT_SIGNED_BY_UNSIGNED, 1'h1, 1'h0, 1'h0);
        mul(CAB_OP_SCALED_PRODUCT_UNSIGNED, 1'h0, 1'h0, 1'h1);
        mul(CAB_OP_SCALED_PRODUCT_SIGNED, 1'h1, 1'h1, 1'h1);
        mul(CAB_OP_SCALED_PRODUCT_MIXED, 1'h1, 1'h0, 1'h1);
        for (i = 0; i < 4; i++)
            compare_immediate(5'h10, i == 0 ? rm[16] : nxt());
        lop(CAB_OP_OR_CONST, 5'h1E, nxt());
        lop(CAB_OP_OR_CONST, 5'h1F, nxt());
        call(CAB_OP_RELATIVE_SUBROUTINE_JUMP, 16'h0FF0);
        call(CAB_OP_SUBROUTINE_EXIT, 16'h0000);
        call(CAB_OP_INDIRECT_SUBROUTINE_JUMP, 16'h0000);
        call(CAB_OP_DIRECT_SUBROUTINE_JUMP, 16'h1234);
        call(CAB_OP_SUBROUTINE_EXIT, 16'h0000);
        call(CAB_OP_INTERRUPT_EXIT, 16'h0000);
        for (i = 0; i < 20; i++)
            skp(i);
        finish_test();
    end
endmodule
`default_nettype wire
